//--- include/fbbm_pkg.sv
// package of the filter bag break monitor: register map, reset values, states, carriers
// assumes a single 100 MHz clock and an AXI4-Lite register bus with 32-bit data
package fbbm_pkg;

  // ----------------------------------------------------------------
  // widths and limits
  // ----------------------------------------------------------------
  localparam int          ADDR_W       = 8;
  localparam int          BAG_W        = 7;
  localparam int          CONC_W       = 16;
  localparam logic [6:0]  MAX_BAGS     = 7'h64;   // 100 bags
  localparam logic [7:0]  LIST_SEP     = 8'h3B;   // semicolon

  // ----------------------------------------------------------------
  // timing: one millisecond tick drives all slow counters
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_PERIOD_US = 1000;
  localparam int TICK_CYCLES   = TICK_PERIOD_US * 1000 / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_BAGS     = 8'h04;
  localparam logic [7:0] OFS_INTERVAL = 8'h08;
  localparam logic [7:0] OFS_DELAY    = 8'h0C;
  localparam logic [7:0] OFS_LIMIT    = 8'h10;
  localparam logic [7:0] OFS_DAMP     = 8'h14;
  localparam logic [7:0] OFS_STATUS   = 8'h18;
  localparam logic [7:0] OFS_CYCLES   = 8'h1C;
  localparam logic [7:0] OFS_CONC     = 8'h20;
  localparam logic [7:0] OFS_IRQ_STS  = 8'h24;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h28;
  localparam logic [7:0] OFS_LIST     = 8'h2C;
  localparam logic [7:0] OFS_LIST_CNT = 8'h30;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_EN_BIT    = 0;
  localparam int CTRL_RELAY_BIT = 1;
  localparam int ST_WAIT_BIT    = 0;
  localparam int ST_RUN_BIT     = 1;
  localparam int ST_BREAK_BIT   = 2;
  localparam int ST_BAG_LSB     = 8;
  localparam int IRQ_START_BIT  = 0;
  localparam int IRQ_DONE_BIT   = 1;
  localparam int IRQ_BREAK_BIT  = 2;
  localparam int LIST_VALID_BIT = 31;
  localparam int LIST_SEP_LSB   = 8;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [6:0]  RST_BAGS     = 7'h64;
  localparam logic [15:0] RST_INTERVAL = 16'h07D0;   // 2000 ms
  localparam logic [15:0] RST_DELAY    = 16'h0000;
  localparam logic [15:0] RST_LIMIT    = 16'h0032;
  localparam logic [3:0]  RST_DAMP     = 4'h0;
  localparam logic [2:0]  RST_IRQ_MASK = 3'h0;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    FBBM_OFF   = 4'b0001,
    FBBM_WAIT  = 4'b0010,
    FBBM_DELAY = 4'b0100,
    FBBM_EVAL  = 4'b1000
  } fbbm_state_type;

  // ----------------------------------------------------------------
  // configuration carrier
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              enable;
    logic              use_relay;
    logic [BAG_W-1:0]  num_bags;
    logic [15:0]       interval_ms;
    logic [15:0]       delay_ms;
    logic [CONC_W-1:0] limit;
    logic [3:0]        damp_shift;
  } fbbm_cfg_type;

endpackage

//--- hdl/fbbm_damp.sv
// first order damping of the concentration for the bag evaluation and the concentration register
// assumes sample_en is a one-cycle pulse and the raw input is a level
`timescale 1ns/1ps
module fbbm_damp
  import fbbm_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              sample_en,
  input  wire logic [3:0]        shift,
  input  wire logic [CONC_W-1:0] raw,
  output logic      [CONC_W-1:0] damped
);

  // ----------------------------------------------------------------
  // accumulator with 8 fraction bits so small steps are not lost
  // ----------------------------------------------------------------
  logic [CONC_W+7:0] acc_q;
  logic [CONC_W+7:0] acc_d;
  logic signed [CONC_W+8:0] diff;
  logic signed [CONC_W+8:0] step;

  // larger shift gives a longer ninety_percent_damping_time
  assign diff  = $signed({1'b0, raw, 8'h00}) - $signed({1'b0, acc_q});
  assign step  = diff >>> shift;
  assign acc_d = CONC_W'(0) + (CONC_W+8)'($signed({1'b0, acc_q}) + step);
  assign damped = acc_q[CONC_W+7:8];

  // update once per tick; the concentration register reads this damped value too
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_q <= '0;
    end else if (sample_en) begin
      acc_q <= acc_d;
    end
  end

endmodule

//--- hdl/fbbm_top.sv
// filter bag break monitor: cycle sequencer, defect list, registers, interrupt
// assumes sync input and concentration are synchronous to aclk, AXI4-Lite master
//
// Decided for this implementation: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module fbbm_top
  import fbbm_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES
)(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              cycle_sync_input,
  input  wire logic [CONC_W-1:0] conc_in,
  output logic                   relay2_q,
  output logic                   running_q,
  output logic                   irq_q,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // byte-lane merge of a write into a 16-bit field
  function automatic logic [15:0] wmerge(input logic [15:0] old,
                                         input logic [31:0] data,
                                         input logic [3:0]  strb);
    logic [15:0] res;
    res = old;
    for (int i = 0; i < 2; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = data[8*i +: 8];
      end
    end
    return res;
  endfunction

  // true when the address names a mapped register
  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    return (a[1:0] == 2'b00) && (a <= OFS_LIST_CNT);
  endfunction

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  fbbm_cfg_type    cfg_q;
  fbbm_state_type  state_q;
  fbbm_state_type  state_d;
  logic [31:0]     tick_cnt_q;
  logic            tick_q;
  logic            sync_s1_q;
  logic            sync_s2_q;
  logic            sync_s3_q;
  logic            sync_rise;
  logic [15:0]     time_q;
  logic [BAG_W-1:0] bag_q;
  logic            bag_hit_q;
  logic            break_q;
  logic [31:0]     cycles_q;
  logic [BAG_W-1:0] list_mem [0:99];
  logic [BAG_W-1:0] list_cnt_q;
  logic [BAG_W-1:0] list_rd_q;
  logic [CONC_W-1:0] damp_conc;
  logic [2:0]      irq_sts_q;
  logic [2:0]      irq_mask_q;
  logic [2:0]      irq_ev;
  logic [2:0]      irq_clr;
  logic [2:0]      irq_sts_d;
  logic [BAG_W-1:0] bags_lim;
  logic            start_ev;
  logic            last_bag;
  logic            interval_end;
  logic            delay_end;
  logic            exceed;
  logic            new_hit;
  logic            done_ev;

  // ----------------------------------------------------------------
  // millisecond tick divider
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b0;
    end else begin
      tick_q     <= (tick_cnt_q == 32'(TICK_DIV - 1));
      tick_cnt_q <= (tick_cnt_q == 32'(TICK_DIV - 1)) ? '0 : tick_cnt_q + 32'h1;
    end
  end

  // ----------------------------------------------------------------
  // sync input: two stage synchroniser then rising edge
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_s1_q <= 1'b0;
      sync_s2_q <= 1'b0;
      sync_s3_q <= 1'b0;
    end else begin
      sync_s1_q <= cycle_sync_input;
      sync_s2_q <= sync_s1_q;
      sync_s3_q <= sync_s2_q;
    end
  end

  // one event per pulse: a held-high input gives no further edge
  assign sync_rise = sync_s2_q & ~sync_s3_q;

  // ----------------------------------------------------------------
  // damped concentration for evaluation and the OFS_CONC read
  // ----------------------------------------------------------------
  fbbm_damp u_fbbm_damp (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .sample_en (tick_q),
    .shift     (cfg_q.damp_shift),
    .raw       (conc_in),
    .damped    (damp_conc)
  );

  // ----------------------------------------------------------------
  // sequencer decode
  // ----------------------------------------------------------------
  // bag count is clamped to the supported range of 1..100
  assign bags_lim = (cfg_q.num_bags > MAX_BAGS) ? MAX_BAGS :
                    (cfg_q.num_bags == '0) ? 7'h01 : cfg_q.num_bags;
  // a pulse restarts the cycle from any enabled state
  assign start_ev     = cfg_q.enable & sync_rise;
  assign delay_end    = (state_q == FBBM_DELAY) && tick_q && (time_q >= cfg_q.delay_ms);
  assign interval_end = (state_q == FBBM_EVAL) && tick_q && (time_q + 16'h1 >= cfg_q.interval_ms);
  assign last_bag     = (bag_q >= bags_lim);
  assign done_ev      = interval_end & last_bag & ~start_ev;
  // compared every cycle while a bag window is open
  assign exceed       = (state_q == FBBM_EVAL) && (damp_conc > cfg_q.limit);
  assign new_hit      = exceed & ~bag_hit_q & ~start_ev;

  // next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      FBBM_OFF: begin
        // a pulse in the enabling cycle must not leave running_q stuck high
        if (start_ev) state_d = FBBM_DELAY;
        else if (cfg_q.enable) state_d = FBBM_WAIT;
      end
      FBBM_WAIT: begin
        if (start_ev) state_d = FBBM_DELAY;
      end
      FBBM_DELAY: begin
        if (start_ev) state_d = FBBM_DELAY;
        else if (delay_end) state_d = FBBM_EVAL;
      end
      FBBM_EVAL: begin
        if (start_ev) state_d = FBBM_DELAY;
        else if (done_ev) state_d = FBBM_WAIT;
      end
      default: state_d = FBBM_OFF;
    endcase
    if (!cfg_q.enable) state_d = FBBM_OFF;
  end

  // ----------------------------------------------------------------
  // sequencer registers
  // ----------------------------------------------------------------
  // time_q counts ms in delay and bag windows; bag_q is 1-based
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q   <= FBBM_OFF;
      time_q    <= '0;
      bag_q     <= '0;
      bag_hit_q <= 1'b0;
      running_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (start_ev) begin
        time_q    <= '0;
        bag_q     <= 7'h01;
        bag_hit_q <= 1'b0;
        running_q <= 1'b1;
      end else if (delay_end) begin
        time_q <= '0;
      end else if (interval_end) begin
        time_q    <= '0;
        bag_hit_q <= 1'b0;
        if (!last_bag) bag_q <= bag_q + 7'h01;
      end else if (tick_q && state_q != FBBM_WAIT) begin
        time_q <= time_q + 16'h1;
      end
      if (new_hit) bag_hit_q <= 1'b1;
      if (done_ev || !cfg_q.enable) running_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // defect list and break indication
  // ----------------------------------------------------------------
  // a bag enters the list once, on its first excess
  always_ff @(posedge aclk) begin
    if (new_hit && list_cnt_q < MAX_BAGS) begin
      list_mem[list_cnt_q] <= bag_q;
    end
  end

  // list is emptied by each start so old defects do not linger
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      list_cnt_q <= '0;
      break_q    <= 1'b0;
      relay2_q   <= 1'b0;
      cycles_q   <= '0;
    end else begin
      if (start_ev) begin
        list_cnt_q <= '0;
        break_q    <= 1'b0;
      end else if (new_hit) begin
        list_cnt_q <= list_cnt_q + 7'h01;
        break_q    <= 1'b1;
      end
      if (done_ev) cycles_q <= cycles_q + 32'h1;
      relay2_q <= cfg_q.use_relay & (break_q | new_hit) & ~start_ev;
    end
  end

  // ----------------------------------------------------------------
  // interrupt: sticky, write one to clear, set wins
  // ----------------------------------------------------------------
  assign irq_ev    = {new_hit, done_ev, start_ev};
  assign irq_sts_d = (irq_sts_q & ~irq_clr) | irq_ev;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_sts_q <= '0;
      irq_q     <= 1'b0;
    end else begin
      irq_sts_q <= irq_sts_d;
      irq_q     <= |(irq_sts_d & irq_mask_q);
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0]       w_data_q;
  logic [3:0]        w_strb_q;
  logic              aw_full_q;
  logic              w_full_q;
  logic              wr_go;
  logic [31:0]       ctrl_rd;

  // address and data are held until both are in and no response is pending
  assign wr_go   = aw_full_q & w_full_q & ~s_axi_bvalid;
  assign irq_clr = (wr_go && aw_addr_q == OFS_IRQ_STS && w_strb_q[0]) ?
                   w_data_q[2:0] : 3'h0;
  assign ctrl_rd = {30'h0, cfg_q.use_relay, cfg_q.enable};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q     <= 1'b0;
      w_full_q      <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
      aw_addr_q     <= '0;
      w_data_q      <= '0;
      w_strb_q      <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_q     <= s_axi_awaddr;
        aw_full_q     <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_q     <= s_axi_wdata;
        w_strb_q     <= s_axi_wstrb;
        w_full_q     <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_full_q     <= 1'b0;
        w_full_q      <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
        s_axi_bvalid  <= 1'b1;
        s_axi_bresp   <= mapped(aw_addr_q) ? 2'b00 : 2'b11;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // configuration registers; read-only offsets ignore writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q.enable      <= 1'b0;
      cfg_q.use_relay   <= 1'b0;
      cfg_q.num_bags    <= RST_BAGS;
      cfg_q.interval_ms <= RST_INTERVAL;
      cfg_q.delay_ms    <= RST_DELAY;
      cfg_q.limit       <= RST_LIMIT;
      cfg_q.damp_shift  <= RST_DAMP;
      irq_mask_q        <= RST_IRQ_MASK;
    end else if (wr_go) begin
      case (aw_addr_q)
        OFS_CTRL: begin
          cfg_q.enable    <= w_strb_q[0] ? w_data_q[CTRL_EN_BIT] : cfg_q.enable;
          cfg_q.use_relay <= w_strb_q[0] ? w_data_q[CTRL_RELAY_BIT] : cfg_q.use_relay;
        end
        OFS_BAGS:     cfg_q.num_bags    <= w_strb_q[0] ? w_data_q[6:0] : cfg_q.num_bags;
        OFS_INTERVAL: cfg_q.interval_ms <= wmerge(cfg_q.interval_ms, w_data_q, w_strb_q);
        OFS_DELAY:    cfg_q.delay_ms    <= wmerge(cfg_q.delay_ms, w_data_q, w_strb_q);
        OFS_LIMIT:    cfg_q.limit       <= wmerge(cfg_q.limit, w_data_q, w_strb_q);
        OFS_DAMP:     cfg_q.damp_shift  <= w_strb_q[0] ? w_data_q[3:0] : cfg_q.damp_shift;
        OFS_IRQ_MASK: irq_mask_q        <= w_strb_q[0] ? w_data_q[2:0] : irq_mask_q;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  logic [31:0] rd_mux;
  logic [31:0] status_rd;
  logic [31:0] list_rd;
  logic        list_pop;

  // list entries come out one per read with the separator alongside
  assign list_rd   = (list_rd_q < list_cnt_q) ?
                     {1'b1, 15'h0, LIST_SEP, 1'b0, list_mem[list_rd_q]} : 32'h0;
  assign status_rd = {16'h0, 1'b0, bag_q, 5'h0, break_q, running_q,
                      (state_q == FBBM_WAIT)};
  assign list_pop  = s_axi_arvalid & s_axi_arready & (s_axi_araddr == OFS_LIST) &
                     (list_rd_q < list_cnt_q);
  assign rd_mux = (s_axi_araddr == OFS_CTRL)     ? ctrl_rd :
                  (s_axi_araddr == OFS_BAGS)     ? {25'h0, cfg_q.num_bags} :
                  (s_axi_araddr == OFS_INTERVAL) ? {16'h0, cfg_q.interval_ms} :
                  (s_axi_araddr == OFS_DELAY)    ? {16'h0, cfg_q.delay_ms} :
                  (s_axi_araddr == OFS_LIMIT)    ? {16'h0, cfg_q.limit} :
                  (s_axi_araddr == OFS_DAMP)     ? {28'h0, cfg_q.damp_shift} :
                  (s_axi_araddr == OFS_STATUS)   ? status_rd :
                  (s_axi_araddr == OFS_CYCLES)   ? cycles_q :
                  (s_axi_araddr == OFS_CONC)     ? {16'h0, damp_conc} :
                  (s_axi_araddr == OFS_IRQ_STS)  ? {29'h0, irq_sts_q} :
                  (s_axi_araddr == OFS_IRQ_MASK) ? {29'h0, irq_mask_q} :
                  (s_axi_araddr == OFS_LIST)     ? list_rd :
                  (s_axi_araddr == OFS_LIST_CNT) ? {25'h0, list_cnt_q} : 32'h0;

  // read pointer rewinds on a new cycle or a list count read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= 2'b00;
      list_rd_q     <= '0;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_mux;
        s_axi_rresp   <= mapped(s_axi_araddr) ? 2'b00 : 2'b11;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
      if (start_ev) begin
        list_rd_q <= '0;
      end else if (s_axi_arvalid && s_axi_arready && s_axi_araddr == OFS_LIST_CNT) begin
        list_rd_q <= '0;
      end else if (list_pop) begin
        list_rd_q <= list_rd_q + 7'h01;
      end
    end
  end

endmodule

//--- tb/fbbm_top_assertions.sv
// port checker of the bag break monitor: bus handshakes and cycle flag
// assumes one clock and a synchronous active low reset
`timescale 1ns/1ps
module fbbm_top_assertions (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic cycle_sync_input,
  input wire logic running_q,
  input wire logic irq_q,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------------------------------------------------------
  // bus timing as handed over, then the cycle flag
  // ----------------------------------------------------------------
  AST_RST: assert property ($rose(aresetn) |-> !running_q && !irq_q && !s_axi_bvalid)
    else $error("outputs not idle after reset");
  AST_WR_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
  AST_AW_WAIT: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("write address taken twice");
  AST_B_ONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer not retired");
  AST_RD_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  AST_R_ONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read answer not retired");
  AST_RUN_START: assert property ($rose(running_q) |-> cycle_sync_input)
    else $error("cycle started without sync pulse");
  AST_RUN_MIN: assert property ($rose(running_q) |=> running_q [*8])
    else $error("running flag dropped early");
  // main scenarios reached
  cover property ($rose(running_q));
  cover property ($fell(running_q));
  cover property ($rose(irq_q));
endmodule

bind fbbm_top fbbm_top_assertions u_fbbm_top_assertions (
  .aclk(aclk), .aresetn(aresetn), .cycle_sync_input(cycle_sync_input),
  .running_q(running_q), .irq_q(irq_q), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);

//--- tb/fbbm_plant_model.sv
// plant cleaning controller: one clean sync pulse per request
// assumes requests come no faster than one bag spacing apart
`timescale 1ns/1ps
module fbbm_plant_model #(
  parameter int MS = 10
)(
  input  wire logic aclk,
  input  wire logic req,
  output logic      sync_level
);
  int cnt_q = 0;
  // debounced 100 ms pulse, no glitch; a request while high is ignored
  always @(posedge aclk) begin
    if (req && cnt_q == 0)
      cnt_q <= 100 * MS;
    else if (cnt_q != 0)
      cnt_q <= cnt_q - 1;
  end
  assign sync_level = (cnt_q != 0);
endmodule

//--- tb/tb_filter_bag_break_monitor.sv
// bench of the bag break monitor: bus tasks, plant model, checks
// assumes TICK_DIV of 10, one millisecond being ten cycles
`timescale 1ns/1ps
module tb_filter_bag_break_monitor;
  import fbbm_pkg::*;
  logic        aclk = 0, aresetn = 0, req = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [15:0] conc = 16'h0;
  logic [1:0]  bresp, rresp, rs;
  logic        sync, relay, run, irq, awready, wready, bvalid, arready, rvalid;
  int          err_count = 0, samples_checked = 0, cyc = 0, len = 0;

  fbbm_top #(.TICK_DIV(10)) u_fbbm_top (
    .aclk(aclk), .aresetn(aresetn), .cycle_sync_input(sync), .conc_in(conc),
    .relay2_q(relay), .running_q(run), .irq_q(irq), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awv), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wv), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  fbbm_plant_model #(.MS(10)) u_fbbm_plant_model (.aclk(aclk), .req(req), .sync_level(sync));

  initial forever #5 aclk = ~aclk;
  // hang guard: three cycles need about 46000 clocks
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (run)
      len <= len + 1;
    if (cyc == 90000) begin
      err_count++;
      print_verdict();
    end
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // list word of one defective bag
  function automatic logic [31:0] exp_list(input logic [6:0] bag);
    return {1'b1, 15'h0, LIST_SEP, 1'b0, bag};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready)
        awv <= 1'b0;
      if (wready)
        wv <= 1'b0;
    end while (awv || wv);
    while (!bvalid) @(posedge aclk);
    rs = bresp;
    bready <= 1'b0;
  endtask
  // read and compare the masked word
  task automatic rdr(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    @(posedge aclk);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arv <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
    chk(rd & m, exp);
  endtask
  // one cleaning cycle of three bags, optional break in bag two
  task automatic cleaning(input bit brk);
    conc <= 16'($urandom_range(0, 50)); // limit itself is no break
    len = 0;
    req <= 1'b1;
    @(posedge aclk);
    req <= 1'b0;
    while (!run) @(posedge aclk);
    rdr(OFS_LIST_CNT, 32'h0, 32'hFFFFFFFF);
    rdr(OFS_STATUS, 32'h0102, 32'h7F07);
    repeat (7000) @(posedge aclk);
    if (brk)
      conc <= 16'($urandom_range(51, 65535));
    repeat (500) @(posedge aclk);
    rdr(OFS_CONC, {16'h0, conc}, 32'hFFFF);
    repeat (500) @(posedge aclk);
    conc <= 16'($urandom_range(0, 50));
    while (run) @(posedge aclk);
    chk((len + 50) / 100, 151);
    $display("cleaning test done, break %0d", brk);
  endtask
  task automatic print_verdict();
    $display("checked %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'hA3BD));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rdr(OFS_BAGS, 32'h64, 32'h7F);
    rdr(OFS_INTERVAL, 32'h7D0, 32'hFFFF);
    rdr(OFS_LIMIT, 32'h32, 32'hFFFF);
    rdr(OFS_CYCLES, 32'h0, 32'hFFFFFFFF);
    rdr(8'h40, 32'h0, 32'hFFFFFFFF);
    chk(rs, 32'h3);
    wr(8'h41, 32'h1);
    chk(rs, 32'h3);
    wr(OFS_BAGS, 32'h3);
    wr(OFS_INTERVAL, 32'h1F4);
    wr(OFS_DELAY, 32'hA);
    wr(OFS_IRQ_MASK, 32'h7);
    wr(OFS_CTRL, 32'h3);
    rdr(OFS_STATUS, 32'h1, 32'h7);
    $display("bus and reset test done");
    cleaning(0);
    rdr(OFS_CYCLES, 32'h1, 32'hFFFFFFFF);
    chk(relay, 32'h0);
    chk(irq, 32'h1);
    rdr(OFS_IRQ_STS, 32'h3, 32'h7);
    wr(OFS_IRQ_STS, 32'h3);
    repeat (2) @(posedge aclk);
    chk(irq, 32'h0);
    cleaning(1);
    rdr(OFS_CYCLES, 32'h2, 32'hFFFFFFFF);
    chk(relay, 32'h1);
    rdr(OFS_LIST_CNT, 32'h1, 32'hFFFFFFFF);
    rdr(OFS_LIST, exp_list(7'h02), 32'hFFFFFFFF);
    rdr(OFS_LIST, 32'h0, 32'hFFFFFFFF);
    wr(OFS_IRQ_MASK, 32'h0);
    repeat (2) @(posedge aclk);
    chk(irq, 32'h0);
    rdr(OFS_IRQ_STS, 32'h7, 32'h7);
    wr(OFS_IRQ_STS, 32'h7);
    cleaning(0);
    chk(relay, 32'h0);
    rdr(OFS_CYCLES, 32'h3, 32'hFFFFFFFF);
    print_verdict();
  end
endmodule
